// File: tacr_ctrl_model.sv
// Calibration controller model driving the serial register port
`timescale 1ns/10ps
module tacr_ctrl_model (
  input  wire logic clk_sys,    // System clock
  output logic      frameSel_n, // Frame select, active low
  output logic      bitStrobe,  // Serial sample pulse
  output logic      bitIn,      // Serial data to the device
  output logic      shiftOut,   // Read data advance pulse
  input  wire logic bitOut,     // Serial data from the device
  input  wire logic bitOutEn    // Device drives read data
);
  // Port idle: deselected, no pulses
  initial begin
    frameSel_n = 1'b1;
    bitStrobe  = 1'b0;
    bitIn      = 1'b0;
    shiftOut   = 1'b0;
  end
  ////////////////////////////////////////
  // One bit: data set up an edge ahead, then a one-cycle strobe
  task automatic putBit(input logic b);
    @(posedge clk_sys) bitIn <= b;
    @(posedge clk_sys) bitStrobe <= 1'b1;
    @(posedge clk_sys) begin
      bitStrobe <= 1'b0;
      bitIn     <= ~b;  // Hold time over, so no stale level is left
    end
  endtask
  // Byte goes out most significant bit first
  task automatic putByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) putBit(b[i]);
  endtask
  // Closing the frame resets the device bit count
  task automatic endFrame;
    @(posedge clk_sys) frameSel_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  // Write frame: instruction, then data bytes to rising addresses
  task automatic writeBurst(input logic [7:0] ins, input logic [7:0] d[$]);
    @(posedge clk_sys) frameSel_n <= 1'b0;
    putByte(ins);
    foreach (d[i]) putByte(d[i]);
    endFrame;
  endtask
  // Read frame; no advance pulse after a byte's last strobe, since the
  // device loads the next byte at that boundary by itself
  task automatic readBurst(input logic [7:0] ins, input int n,
                           output logic [7:0] q[$], output logic en);
    logic [7:0] b;
    q  = {};
    en = 1'b1;
    @(posedge clk_sys) frameSel_n <= 1'b0;
    putByte(ins);
    repeat (n) begin
      for (int i = 7; i >= 0; i--) begin
        repeat (2) @(posedge clk_sys);
        b[i] = bitOut;
        en   = en & bitOutEn;
        bitStrobe <= 1'b1;
        @(posedge clk_sys) begin
          bitStrobe <= 1'b0;
          shiftOut  <= (i > 0);
        end
        @(posedge clk_sys) shiftOut <= 1'b0;
      end
      q.push_back(b);
    end
    endFrame;
  endtask
endmodule

// File: tacr_pkg.sv
// Package: register map, field layout and constants of the analog config bank
package tacr_pkg;
  localparam logic [3:0] ADDR_GAIN      = 4'h6;
  localparam logic [3:0] ADDR_ALARM     = 4'h7;
  localparam logic [3:0] ADDR_INSEL     = 4'h8;
  localparam logic [3:0] ADDR_REFROUTE  = 4'h9;
  localparam logic [3:0] ADDR_REFFINE   = 4'hA;
  localparam logic [3:0] ADDR_REFCOARSE = 4'hB;
  localparam logic [3:0] ADDR_ZFINE     = 4'hC;
  localparam logic [3:0] ADDR_ZCOARSE   = 4'hD;
  localparam logic [3:0] ADDR_LIN       = 4'hE;
  localparam logic [3:0] ADDR_CHECKSUM  = 4'hF;
  localparam int         FIRST_IDX      = 6;
  localparam int         NUM_REGS       = 10;
  // Instruction byte layout
  localparam int         INSTR_RD_BIT   = 7;
  localparam logic [2:0] INSTR_ZERO     = 3'h0;
  // Field positions
  localparam int         POS_HI_LSB     = 4;
  localparam int         POS_LO_LSB     = 0;
  localparam logic [2:0] SEL_MAX        = 3'h5;
  localparam logic [2:0] GAIN_MAX       = 3'h6;
  localparam logic [7:0] RESET_VAL      = 8'h00;
  localparam logic [7:0] RESERVED_READ  = 8'h00;
  localparam logic [2:0] UNDERSCALE_LOW = 3'h7;
  localparam logic [7:0] CHECKSUM_SEED  = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_INSTR = 3'b001,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b011,
    ST_SKIP  = 3'b100
  } tacr_state_t;
endpackage

// File: tacr_regs.sv
// Module: analog configuration register bank behind the serial port
`timescale 1ns/10ps
module tacr_regs
  import tacr_pkg::*;
(
  input  wire logic        clk_sys,        // System clock 50 MHz
  input  wire logic        reset_n,        // Async reset, active low
  input  wire logic        frameSel_n,     // Frame select, active low
  input  wire logic        bitStrobe,      // Pulse: serial bit sample point
  input  wire logic        bitIn,          // Serial data in at strobe
  input  wire logic        shiftOut,       // Pulse: advance read data bit
  output logic             bitOut,         // Serial read data
  output logic             bitOutEn,       // High while driving read data
  output logic [2:0]       ampGain,        // Amplifier gain code
  output logic [7:0]       alarmDir,       // Fault to alarm direction map
  output logic [2:0]       posInputSel,    // Positive input pin select
  output logic [2:0]       negInputSel,    // Negative input pin select
  output logic [2:0]       firstRefRoute,  // First reference current route
  output logic [2:0]       secondRefRoute, // Second reference current route
  output logic [7:0]       refFineCode,    // Fine reference DAC code
  output logic [7:0]       refCoarseCode,  // Coarse reference DAC code
  output logic [7:0]       zeroFineCode,   // Fine zero DAC code, signed
  output logic [7:0]       zeroCoarseCode, // Coarse zero DAC code, signed
  output logic [7:0]       linearizeCode,  // Linearization DAC code
  output logic             checksumErrorFlag, // Checksum error flag
  output logic             forceUnderscale,   // Force lowest under-scale
  output logic [2:0]       underscaleSel   // Under-scale level override
);
  import tacr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Replaceable validity check: byte sum of all stored registers is zero
  function automatic logic sumValid(input logic [7:0] r [NUM_REGS]);
    logic [7:0] acc;
    acc = CHECKSUM_SEED;
    for (int i = 0; i < NUM_REGS; i++) begin
      acc = acc + r[i];
    end
    return acc == 8'h00;
  endfunction

  // True if the address maps to a storage index; mapped only for 6..15
  function automatic logic addrMapped(input logic [3:0] a);
    return a >= 4'(FIRST_IDX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial state

  tacr_state_t stateQ, stateD;
  logic [2:0]  bitCntQ, bitCntD;
  logic [7:0]  shiftQ, shiftD;
  logic [3:0]  addrQ, addrD;
  logic [7:0]  txQ, txD;
  logic        oeQ, oeD;
  logic [7:0]  regQ [NUM_REGS];
  logic [7:0]  regD [NUM_REGS];
  logic        cseQ, cseD;
  logic [7:0]  shiftNext;
  logic        byteDone;
  logic [3:0]  idx;

  assign shiftNext = {shiftQ[6:0], bitIn};
  assign byteDone  = bitStrobe && (bitCntQ == 3'h7);
  assign idx       = 4'(addrQ - 4'(FIRST_IDX));

  // Next state of the serial engine and the register file
  always_comb begin
    stateD  = stateQ;
    bitCntD = bitCntQ;
    shiftD  = shiftQ;
    addrD   = addrQ;
    txD     = txQ;
    oeD     = oeQ;
    cseD    = cseQ;
    for (int i = 0; i < NUM_REGS; i++) begin
      regD[i] = regQ[i];
    end
    if (frameSel_n) begin
      // Frame end always resets the engine and releases the data line
      stateD  = ST_IDLE;
      bitCntD = 3'h0;
      oeD     = 1'b0;
    end else begin
      if (stateQ == ST_IDLE) begin
        stateD = ST_INSTR;
      end
      if (bitStrobe) begin
        bitCntD = 3'(bitCntQ + 3'h1);
        shiftD  = shiftNext;
      end
      if (shiftOut && oeQ) begin
        txD = {txQ[6:0], 1'b0};
      end
      if (byteDone) begin
        case (stateQ)
          ST_IDLE, ST_INSTR: begin
            addrD = shiftNext[3:0];
            if (shiftNext[6:4] != INSTR_ZERO) begin
              // Bad instruction: ignore the rest of the frame, so a long run
              // of data bytes can never wrap round into the bank
              stateD = ST_SKIP;
            end else if (shiftNext[INSTR_RD_BIT]) begin
              stateD = ST_RDATA;
              oeD    = 1'b1;
            end else begin
              stateD = ST_WDATA;
            end
          end
          ST_WDATA: begin
            if (addrMapped(addrQ)) begin
              regD[idx] = shiftNext;
            end
            if (addrQ == ADDR_CHECKSUM) begin
              cseD = !sumValid(regD);
            end
            addrD = 4'(addrQ + 4'h1);
          end
          ST_RDATA: begin
            addrD = 4'(addrQ + 4'h1);
          end
          ST_SKIP: begin
            stateD = ST_SKIP; // Wait for frame select to rise
          end
          default: begin
            stateD = ST_IDLE;
          end
        endcase
      end
      // Load read byte once the address of the next byte is known; read
      // inline so this process never waits on a value it computes itself
      if (byteDone && (stateD == ST_RDATA)) begin
        txD = RESERVED_READ; // Unmapped addresses read as zero
        if (addrMapped(addrD)) begin
          txD = regD[4'(addrD - 4'(FIRST_IDX))];
        end
      end
    end
  end

  // Register the serial engine
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stateQ  <= ST_IDLE;
      bitCntQ <= 3'h0;
      shiftQ  <= 8'h00;
      addrQ   <= 4'h0;
      txQ     <= 8'h00;
      oeQ     <= 1'b0;
      cseQ    <= 1'b0;
    end else begin
      stateQ  <= stateD;
      bitCntQ <= bitCntD;
      shiftQ  <= shiftD;
      addrQ   <= addrD;
      txQ     <= txD;
      oeQ     <= oeD;
      cseQ    <= cseD;
    end
  end

  // Register storage, one flop byte per mapped address (6..15)
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : gReg
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          regQ[g] <= RESET_VAL;
        end else begin
          regQ[g] <= regD[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered

  logic [2:0] gainD;
  logic [2:0] posD;
  logic [2:0] negD;
  logic [2:0] rAD;
  logic [2:0] rBD;

  // Reserved codes are held at the last legal value so analog never sees them
  always_comb begin
    gainD = regD[ADDR_GAIN - 4'(FIRST_IDX)][2:0];
    if (gainD > GAIN_MAX) begin
      gainD = ampGain;
    end
    posD = regD[ADDR_INSEL - 4'(FIRST_IDX)][POS_HI_LSB +: 3];
    if (posD > SEL_MAX) begin
      posD = posInputSel;
    end
    negD = regD[ADDR_INSEL - 4'(FIRST_IDX)][POS_LO_LSB +: 3];
    if (negD > SEL_MAX) begin
      negD = negInputSel;
    end
    rAD = regD[ADDR_REFROUTE - 4'(FIRST_IDX)][POS_LO_LSB +: 3];
    if (rAD > SEL_MAX) begin
      rAD = firstRefRoute;
    end
    rBD = regD[ADDR_REFROUTE - 4'(FIRST_IDX)][POS_HI_LSB +: 3];
    if (rBD > SEL_MAX) begin
      rBD = secondRefRoute;
    end
  end

  // Output registers load from the next-state bytes, so they update on the same edge as the stored bytes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ampGain           <= 3'h0;
      alarmDir          <= 8'h00;
      posInputSel       <= 3'h0;
      negInputSel       <= 3'h0;
      firstRefRoute     <= 3'h0;
      secondRefRoute    <= 3'h0;
      refFineCode       <= 8'h00;
      refCoarseCode     <= 8'h00;
      zeroFineCode      <= 8'h00;
      zeroCoarseCode    <= 8'h00;
      linearizeCode     <= 8'h00;
      checksumErrorFlag <= 1'b0;
      forceUnderscale   <= 1'b0;
      underscaleSel     <= 3'h0;
      bitOut            <= 1'b0;
      bitOutEn          <= 1'b0;
    end else begin
      ampGain           <= gainD;
      alarmDir          <= regD[ADDR_ALARM - 4'(FIRST_IDX)];
      posInputSel       <= posD;
      negInputSel       <= negD;
      firstRefRoute     <= rAD;
      secondRefRoute    <= rBD;
      refFineCode       <= regD[ADDR_REFFINE - 4'(FIRST_IDX)];
      refCoarseCode     <= regD[ADDR_REFCOARSE - 4'(FIRST_IDX)];
      zeroFineCode      <= regD[ADDR_ZFINE - 4'(FIRST_IDX)];
      zeroCoarseCode    <= regD[ADDR_ZCOARSE - 4'(FIRST_IDX)];
      linearizeCode     <= regD[ADDR_LIN - 4'(FIRST_IDX)];
      checksumErrorFlag <= cseD;
      forceUnderscale   <= cseD;
      underscaleSel     <= cseD ? UNDERSCALE_LOW : 3'h0;
      bitOut            <= txD[7];
      bitOutEn          <= oeD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions, all on the system clock and quiet during reset

  default clocking cbAst @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  AST_GAIN_LEGAL: assert property (ampGain <= GAIN_MAX)
    else $error("gain reserved code");
  AST_POS_LEGAL: assert property (posInputSel <= SEL_MAX)
    else $error("pos sel reserved");
  AST_NEG_LEGAL: assert property (negInputSel <= SEL_MAX)
    else $error("neg sel reserved");
  AST_ROUTE_LEGAL: assert property (
    firstRefRoute <= SEL_MAX && secondRefRoute <= SEL_MAX)
    else $error("route reserved");
  AST_CSE_SET: assert property (
    byteDone && !frameSel_n && stateQ == ST_WDATA && addrQ == ADDR_CHECKSUM
    && !sumValid(regD) |=> cseQ) else $error("cse not set");
  AST_CSE_CLR: assert property (
    byteDone && !frameSel_n && stateQ == ST_WDATA && addrQ == ADDR_CHECKSUM
    && sumValid(regD) |=> !cseQ) else $error("cse not cleared");
  AST_CSE_HOLD: assert property (
    !(byteDone && stateQ == ST_WDATA) |=> $stable(cseQ))
    else $error("cse moved");
  // Flag and force are launched together, so they must agree every cycle
  AST_FORCE: assert property (
    forceUnderscale == cseQ
    && underscaleSel == (cseQ ? UNDERSCALE_LOW : 3'h0))
    else $error("no underscale force");
  AST_AUTOINC: assert property (
    byteDone && !frameSel_n && (stateQ == ST_WDATA || stateQ == ST_RDATA)
    |=> addrQ == 4'($past(addrQ) + 4'h1)) else $error("no autoinc");
  AST_LIN_WRITE: assert property (
    byteDone && !frameSel_n && stateQ == ST_WDATA && addrQ == ADDR_LIN
    |=> ##1 linearizeCode == $past(shiftNext, 2)) else $error("lin");
  AST_SKIP_QUIET: assert property (
    stateQ == ST_SKIP |=> !bitOutEn && $stable(cseQ))
    else $error("refused frame acted");

  COV_WRITE: cover property (byteDone && stateQ == ST_WDATA);
  COV_READ: cover property (byteDone && stateQ == ST_RDATA);
  COV_CSE: cover property ($rose(cseQ));
  COV_CSE_CLR: cover property ($fell(cseQ));
  COV_SKIP: cover property (byteDone && stateQ == ST_SKIP);
endmodule

// File: tacr_regs_bench.sv
// Self-checking bench for the analog configuration register bank
`timescale 1ns/10ps
module tacr_regs_bench;
  import tacr_pkg::*;
  logic       clk_sys, reset_n, frameSel_n, bitStrobe, bitIn, shiftOut;
  logic       bitOut, bitOutEn, checksumErrorFlag, forceUnderscale;
  logic [2:0] ampGain, posInputSel, negInputSel, underscaleSel;
  logic [2:0] firstRefRoute, secondRefRoute;
  logic [7:0] alarmDir, refFineCode, refCoarseCode, zeroFineCode;
  logic [7:0] zeroCoarseCode, linearizeCode;
  logic [7:0] shadow [16];
  logic [2:0] expGain, expPos, expNeg, expR1, expR2;
  logic       expCse;
  int         fail_count, num_checks;

  tacr_regs i_tacr_regs (.clk_sys, .reset_n, .frameSel_n, .bitStrobe,
    .bitIn, .shiftOut, .bitOut, .bitOutEn, .ampGain, .alarmDir,
    .posInputSel, .negInputSel, .firstRefRoute, .secondRefRoute,
    .refFineCode, .refCoarseCode, .zeroFineCode, .zeroCoarseCode,
    .linearizeCode, .checksumErrorFlag, .forceUnderscale, .underscaleSel);
  tacr_ctrl_model i_tacr_ctrl_model (.clk_sys, .frameSel_n, .bitStrobe,
    .bitIn, .shiftOut, .bitOut, .bitOutEn);
  ////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Watchdog: the run needs about 1600 cycles, this allows 20000
  initial begin
    #400000;
    fail_count++;
    $display("watchdog expired");
    print_verdict;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  ////////////////////////////////////////
  // Reference model of the bank: reserved codes leave the outputs alone
  function automatic logic [7:0] cfgSum();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 6; i < 16; i++) s = s + shadow[i];
    return s;
  endfunction
  function automatic void apply(input logic [3:0] a, input logic [7:0] d);
    if (a < ADDR_GAIN) return;
    shadow[a] = d;
    if (a == ADDR_GAIN && d[2:0] <= GAIN_MAX) expGain = d[2:0];
    if (a == ADDR_INSEL && d[6:4] <= SEL_MAX) expPos = d[6:4];
    if (a == ADDR_INSEL && d[2:0] <= SEL_MAX) expNeg = d[2:0];
    if (a == ADDR_REFROUTE && d[2:0] <= SEL_MAX) expR1 = d[2:0];
    if (a == ADDR_REFROUTE && d[6:4] <= SEL_MAX) expR2 = d[6:4];
    if (a == ADDR_CHECKSUM) expCse = (cfgSum() != 8'h00);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
    i_tacr_ctrl_model.writeBurst({1'b0, INSTR_ZERO, a}, d);
    foreach (d[i]) apply(a + 4'(i), d[i]);
  endtask
  task automatic rdChk(input logic [3:0] a, input int n);
    logic [7:0] q[$];
    logic       en;
    logic [3:0] k;
    i_tacr_ctrl_model.readBurst({1'b1, INSTR_ZERO, a}, n, q, en);
    check("drive enable", {7'h00, en}, 8'h01);
    check("drive release", {7'h00, bitOutEn}, 8'h00);
    foreach (q[i]) begin
      k = a + 4'(i);
      check("read", q[i], (k < ADDR_GAIN) ? RESERVED_READ : shadow[k]);
    end
  endtask
  // Compare every field output against the model, settled at mid-cycle
  task automatic chkAll;
    @(negedge clk_sys);
    check("gain", {5'h00, ampGain}, {5'h00, expGain});
    check("alarm", alarmDir, shadow[7]);
    check("pos sel", {5'h00, posInputSel}, {5'h00, expPos});
    check("neg sel", {5'h00, negInputSel}, {5'h00, expNeg});
    check("route 1", {5'h00, firstRefRoute}, {5'h00, expR1});
    check("route 2", {5'h00, secondRefRoute}, {5'h00, expR2});
    check("ref fine", refFineCode, shadow[10]);
    check("ref coarse", refCoarseCode, shadow[11]);
    check("zero fine", zeroFineCode, shadow[12]);
    check("zero coarse", zeroCoarseCode, shadow[13]);
    check("linearize", linearizeCode, shadow[14]);
    check("sum err", {7'h00, checksumErrorFlag}, {7'h00, expCse});
    check("force", {7'h00, forceUnderscale}, {7'h00, expCse});
    check("us sel", {5'h00, underscaleSel},
          expCse ? {5'h00, UNDERSCALE_LOW} : 8'h00);
  endtask
  ////////////////////////////////////////
  // Burst write across all field registers, then a burst read back
  task automatic tBurst;
    wr(ADDR_GAIN, {8'h03, 8'hA5, 8'h52, 8'h14, 8'h80, 8'h7F, 8'hFF,
                   8'h81, 8'hFE});
    chkAll;
    rdChk(ADDR_GAIN, 4);
    $display("test burst done");
  endtask
  // Every gain code, the reserved one last; reserved selects held off
  task automatic tGain;
    for (int g = 0; g < 8; g++) begin
      wr(ADDR_GAIN, {8'(g)});
      chkAll;
    end
    rdChk(ADDR_GAIN, 1);
    wr(ADDR_INSEL, {8'h67});
    wr(ADDR_REFROUTE, {8'h76});
    chkAll;
    $display("test codes done");
  endtask
  // Bad sum raises the error and forces under-scale, good sum clears it
  task automatic tSum;
    logic [7:0] good;
    good = shadow[15] - cfgSum();
    wr(ADDR_CHECKSUM, {good + 8'h01});
    chkAll;
    wr(ADDR_CHECKSUM, {good});
    chkAll;
    rdChk(ADDR_CHECKSUM, 2);
    $display("test checksum done");
  endtask
  // Malformed instruction and writes below the bank are ignored
  task automatic tRefuse;
    // Seven bytes: if accepted they would land on addresses 6 to 12 of the bank
    i_tacr_ctrl_model.writeBurst(8'h16, {8'h55, 8'h55, 8'h55, 8'h55, 8'h55,
                                         8'h55, 8'h55});
    chkAll;
    wr(4'h5, {8'hAA, 8'h02});
    chkAll;
    rdChk(4'h5, 2);
    $display("test refuse done");
  endtask
  ////////////////////////////////////////
  initial begin
    fail_count = 0;
    num_checks = 0;
    foreach (shadow[i]) shadow[i] = RESET_VAL;
    {expGain, expPos, expNeg, expR1, expR2, expCse} = '0;
    reset_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    chkAll;
    $display("test reset done");
    tBurst;
    tGain;
    tSum;
    tRefuse;
    print_verdict;
  end
endmodule
